// ==== dv/iflsb_properties.sv ====
`timescale 1ns/1ps

module iflsb_props (
    input wire mclk,
    input wire rst_n,
    input wire [3:0] ch1_open,
    input wire ch1_pair_short,
    input wire [7:0] ch1_pin_faults,
    input wire [7:0] reg_addr,
    input wire reg_rd,
    input wire reg_wr,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    input wire reg_miss,
    input wire reg_wr_ignored,
    input wire [7:0] channel_fault_summary,
    input wire fault_present
);
    // ---------------------------------------------
    // properties
    // ---------------------------------------------
    // status lags detectors by one edge, so reads see inputs from two edges back
    wire [7:0] ch1_exp = {|ch1_open, ch1_pair_short, ch1_pin_faults[5:0]};
    wire ch1_any = |ch1_exp;
    wire mapped = reg_addr >= 8'h2D && reg_addr <= 8'h31;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    read_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    no_spur_a: assert property (!reg_rd |=> !reg_rvalid)
        else $error("spurious read valid");
    ch1_data_a: assert property (reg_rd && reg_addr == 8'h2E && $past(rst_n)
        |=> reg_rdata == $past(ch1_exp, 2))
        else $error("channel one read data wrong");
    miss_zero_a: assert property (reg_rd && !mapped |=> reg_miss && reg_rdata == 8'h00)
        else $error("unmapped read wrong");
    write_drop_a: assert property (reg_wr && !reg_rd |=> reg_wr_ignored)
        else $error("write not flagged ignored");
    sum_ch1_a: assert property ($past(rst_n) && $past(rst_n, 2)
        |-> channel_fault_summary[7] == $past(ch1_any, 2))
        else $error("summary channel one wrong");
    rst_out_a: assert property (!$past(rst_n)
        |-> channel_fault_summary == 8'h00 && !fault_present && !reg_rvalid && reg_rdata == 8'h00)
        else $error("outputs not cleared by reset");
    sum_resv_a: assert property (channel_fault_summary[3:2] == 2'b00 && !channel_fault_summary[0])
        else $error("summary reserved bits set");
    any_fault_a: assert property (fault_present == |channel_fault_summary[7:4])
        else $error("fault present disagrees with summary");
    cover property (reg_rd && reg_addr == 8'h2E);
    cover property (reg_wr);
    cover property (fault_present);
endmodule

bind iflsb_top iflsb_props iflsb_props_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .ch1_open(ch1_open),
    .ch1_pair_short(ch1_pair_short),
    .ch1_pin_faults(ch1_pin_faults),
    .reg_addr(reg_addr),
    .reg_rd(reg_rd),
    .reg_wr(reg_wr),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .reg_miss(reg_miss),
    .reg_wr_ignored(reg_wr_ignored),
    .channel_fault_summary(channel_fault_summary),
    .fault_present(fault_present)
);

// ==== dv/input_fault_live_status_bank_tb.sv ====
`timescale 1ns/1ps

module input_fault_live_status_bank_tb;
    // ---------------------------------------------
    // stimulus
    // ---------------------------------------------
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] op [4];
    logic pr [4];
    logic [7:0] pf [4];
    logic vbat = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    wire [7:0] reg_rdata;
    wire [7:0] sum;
    wire reg_rvalid, reg_miss, reg_wr_ignored, fault_present;
    int errors = 0;
    int total_checks = 0;
    // open lanes, pair short, pin faults, expected status
    logic [20:0] rows [10] = '{{4'h1, 1'b0, 8'h00, 8'h80}, {4'h8, 1'b0, 8'h00, 8'h80},
        {4'h0, 1'b1, 8'h00, 8'h40}, {4'h0, 1'b0, 8'h20, 8'h20}, {4'h0, 1'b0, 8'h10, 8'h10},
        {4'h0, 1'b0, 8'h08, 8'h08}, {4'h0, 1'b0, 8'h04, 8'h04}, {4'h0, 1'b0, 8'h02, 8'h02},
        {4'h0, 1'b0, 8'h01, 8'h01}, {4'h0, 1'b0, 8'hC0, 8'h00}};
    always #12.5 mclk = ~mclk;
    iflsb_top iflsb_top_i (.mclk(mclk), .rst_n(rst_n), .ch1_open(op[0]), .ch2_open(op[1]),
        .ch3_open(op[2]), .ch4_open(op[3]), .ch1_pair_short(pr[0]), .ch2_pair_short(pr[1]),
        .ch3_pair_short(pr[2]), .ch4_pair_short(pr[3]), .ch1_pin_faults(pf[0]),
        .ch2_pin_faults(pf[1]), .ch3_pin_faults(pf[2]), .ch4_pin_faults(pf[3]),
        .vbat_below_bias(vbat), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_miss(reg_miss), .reg_wr_ignored(reg_wr_ignored),
        .channel_fault_summary(sum), .fault_present(fault_present));
    // ---------------------------------------------
    // tasks
    // ---------------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    task put(input int c, input logic [20:0] r);
        @(posedge mclk);
        for (int i = 0; i < 4; i++) begin
            op[i] <= (i == c) ? r[20:17] : 4'h0;
            pr[i] <= (i == c) ? r[16] : 1'b0;
            pf[i] <= (i == c) ? r[15:8] : 8'h00;
        end
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e, input logic m);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, e);
        chk({7'h00, reg_miss}, {7'h00, m});
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ---------------------------------------------
    // sequence
    // ---------------------------------------------
    initial begin
        for (int i = 0; i < 4; i++) begin
            op[i] = 4'h0;
            pr[i] = 1'b0;
            pf[i] = 8'h00;
        end
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        for (int a = 0; a < 5; a++) rd(8'(8'h2D + a), 8'h00, 1'b0);
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 10; r++) begin
                put(c, rows[r]);
                rd(8'(8'h2E + c), rows[r][7:0], 1'b0);
                chk(sum, (rows[r][7:0] != 0 ? 8'h80 >> c : 8'h00) | {6'h00, |rows[r][1:0], 1'b0});
                chk({7'h00, fault_present}, {7'h00, rows[r][7:0] != 0});
            end
        end
        // battery short is only summarised while the rail sits below bias
        put(1, rows[7]);
        vbat <= 1'b0;
        rd(8'h2F, 8'h02, 1'b0);
        chk(sum, 8'h40);
        put(0, rows[2]);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= 8'h2E;
        reg_wdata <= 8'hFF;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(negedge mclk);
        chk({7'h00, reg_wr_ignored}, 8'h01);
        rd(8'h2E, 8'h40, 1'b0);
        rd(8'h32, 8'h00, 1'b1);
        put(0, 21'h0);
        rd(8'h2E, 8'h00, 1'b0);
        // mid-run reset with a fault standing: outputs clear and the
        // live word only reloads once reset has gone
        put(0, rows[2]);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        chk(sum, 8'h00);
        chk({7'h00, fault_present}, 8'h00);
        @(negedge mclk);
        chk(sum, 8'h00);
        @(negedge mclk);
        chk(sum, 8'h80);
        rd(8'h2E, 8'h40, 1'b0);
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        end_of_test();
    end
endmodule

// ==== logic/iflsb_chan.v ====
`timescale 1ns/1ps
`include "iflsb_map.vh"

// ---------------------------------------------------------------
// one channel live fault status register
// ---------------------------------------------------------------
module iflsb_chan (
    input wire mclk,
    input wire rst_n,
    input wire [7:0] fault_in,
    output wire [7:0] live_status,
    output wire vbat_short,
    output wire any_fault
);
    reg [7:0] live_reg;

    // recaptured every cycle so a cleared fault drops at once
    always @(posedge mclk) begin
        if (!rst_n) begin
            live_reg <= `IFLSB_RST_LIVE;
        end else begin
            live_reg <= fault_in;
        end
    end

    assign live_status = live_reg;
    assign vbat_short = live_reg[`IFLSB_BIT_POS_VBAT] | live_reg[`IFLSB_BIT_NEG_VBAT];
    assign any_fault = |live_reg;
endmodule

// ==== logic/iflsb_rdmux.v ====
`timescale 1ns/1ps
`include "iflsb_map.vh"

// ---------------------------------------------------------------
// read address decode
// ---------------------------------------------------------------
module iflsb_rdmux (
    input wire [7:0] addr,
    input wire [7:0] summary,
    input wire [7:0] ch1,
    input wire [7:0] ch2,
    input wire [7:0] ch3,
    input wire [7:0] ch4,
    output reg [7:0] data,
    output reg hit
);
    always @* begin
        data = `IFLSB_UNMAPPED_DATA;
        hit = 1'h1;
        case (addr)
            `IFLSB_OFS_SUMMARY: begin
                data = summary;
            end
            `IFLSB_OFS_CH1: begin
                data = ch1;
            end
            `IFLSB_OFS_CH2: begin
                data = ch2;
            end
            `IFLSB_OFS_CH3: begin
                data = ch3;
            end
            `IFLSB_OFS_CH4: begin
                data = ch4;
            end
            default: begin
                data = `IFLSB_UNMAPPED_DATA;
                hit = 1'h0;
            end
        endcase
    end
endmodule

// ==== logic/iflsb_top.v ====
`timescale 1ns/1ps
`include "iflsb_map.vh"


module iflsb_top (
    input wire mclk,
    input wire rst_n,
    input wire [3:0] ch1_open,
    input wire [3:0] ch2_open,
    input wire ch1_pair_short,
    input wire ch2_pair_short,
    input wire ch3_pair_short,
    input wire ch4_pair_short,
    input wire [3:0] ch3_open,
    input wire [3:0] ch4_open,
    input wire [7:0] ch1_pin_faults,
    input wire [7:0] ch2_pin_faults,
    input wire [7:0] ch3_pin_faults,
    input wire [7:0] ch4_pin_faults,
    input wire vbat_below_bias,
    input wire [7:0] reg_addr,
    input wire reg_rd,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    output reg reg_miss,
    output reg reg_wr_ignored,
    output reg [7:0] channel_fault_summary,
    output reg fault_present
);
    // ---------------------------------------------------------------
    // detector decode
    // ---------------------------------------------------------------
    // pin faults arrive as {pos_gnd, neg_gnd, pos_bias, neg_bias,
    // pos_vbat, neg_vbat} in bits 5..0; bits 7..6 are unused there
    // open arrives as a 4-wide vote; any asserted lane counts, so a
    // single lane stuck low cannot hide an open input
    wire ch1_open_any;
    wire ch1_pos_gnd;
    wire ch1_neg_gnd;
    wire ch1_pos_bias;
    wire ch1_neg_bias;
    wire ch1_pos_vbat;
    wire ch1_neg_vbat;

    wire ch2_open_any;
    wire ch2_pos_gnd;
    wire ch2_neg_gnd;
    wire ch2_pos_bias;
    wire ch2_neg_bias;
    wire ch2_pos_vbat;
    wire ch2_neg_vbat;

    wire ch3_open_any;
    wire ch3_pos_gnd;
    wire ch3_neg_gnd;
    wire ch3_pos_bias;
    wire ch3_neg_bias;
    wire ch3_pos_vbat;
    wire ch3_neg_vbat;

    wire ch4_open_any;
    wire ch4_pos_gnd;
    wire ch4_neg_gnd;
    wire ch4_pos_bias;
    wire ch4_neg_bias;
    wire ch4_pos_vbat;
    wire ch4_neg_vbat;

    assign ch1_open_any = |ch1_open;
    assign ch1_pos_gnd = ch1_pin_faults[`IFLSB_BIT_POS_GND];
    assign ch1_neg_gnd = ch1_pin_faults[`IFLSB_BIT_NEG_GND];
    assign ch1_pos_bias = ch1_pin_faults[`IFLSB_BIT_POS_BIAS];
    assign ch1_neg_bias = ch1_pin_faults[`IFLSB_BIT_NEG_BIAS];
    assign ch1_pos_vbat = ch1_pin_faults[`IFLSB_BIT_POS_VBAT];
    assign ch1_neg_vbat = ch1_pin_faults[`IFLSB_BIT_NEG_VBAT];

    assign ch2_open_any = |ch2_open;
    assign ch2_pos_gnd = ch2_pin_faults[`IFLSB_BIT_POS_GND];
    assign ch2_neg_gnd = ch2_pin_faults[`IFLSB_BIT_NEG_GND];
    assign ch2_pos_bias = ch2_pin_faults[`IFLSB_BIT_POS_BIAS];
    assign ch2_neg_bias = ch2_pin_faults[`IFLSB_BIT_NEG_BIAS];
    assign ch2_pos_vbat = ch2_pin_faults[`IFLSB_BIT_POS_VBAT];
    assign ch2_neg_vbat = ch2_pin_faults[`IFLSB_BIT_NEG_VBAT];

    assign ch3_open_any = |ch3_open;
    assign ch3_pos_gnd = ch3_pin_faults[`IFLSB_BIT_POS_GND];
    assign ch3_neg_gnd = ch3_pin_faults[`IFLSB_BIT_NEG_GND];
    assign ch3_pos_bias = ch3_pin_faults[`IFLSB_BIT_POS_BIAS];
    assign ch3_neg_bias = ch3_pin_faults[`IFLSB_BIT_NEG_BIAS];
    assign ch3_pos_vbat = ch3_pin_faults[`IFLSB_BIT_POS_VBAT];
    assign ch3_neg_vbat = ch3_pin_faults[`IFLSB_BIT_NEG_VBAT];

    assign ch4_open_any = |ch4_open;
    assign ch4_pos_gnd = ch4_pin_faults[`IFLSB_BIT_POS_GND];
    assign ch4_neg_gnd = ch4_pin_faults[`IFLSB_BIT_NEG_GND];
    assign ch4_pos_bias = ch4_pin_faults[`IFLSB_BIT_POS_BIAS];
    assign ch4_neg_bias = ch4_pin_faults[`IFLSB_BIT_NEG_BIAS];
    assign ch4_pos_vbat = ch4_pin_faults[`IFLSB_BIT_POS_VBAT];
    assign ch4_neg_vbat = ch4_pin_faults[`IFLSB_BIT_NEG_VBAT];

    // ---------------------------------------------------------------
    // status words
    // ---------------------------------------------------------------
    wire [7:0] ch1_bundle;
    wire [7:0] ch2_bundle;
    wire [7:0] ch3_bundle;
    wire [7:0] ch4_bundle;

    assign ch1_bundle[`IFLSB_BIT_OPEN] = ch1_open_any;
    assign ch1_bundle[`IFLSB_BIT_PAIR_SHORT] = ch1_pair_short;
    assign ch1_bundle[`IFLSB_BIT_POS_GND] = ch1_pos_gnd;
    assign ch1_bundle[`IFLSB_BIT_NEG_GND] = ch1_neg_gnd;
    assign ch1_bundle[`IFLSB_BIT_POS_BIAS] = ch1_pos_bias;
    assign ch1_bundle[`IFLSB_BIT_NEG_BIAS] = ch1_neg_bias;
    assign ch1_bundle[`IFLSB_BIT_POS_VBAT] = ch1_pos_vbat;
    assign ch1_bundle[`IFLSB_BIT_NEG_VBAT] = ch1_neg_vbat;

    assign ch2_bundle[`IFLSB_BIT_OPEN] = ch2_open_any;
    assign ch2_bundle[`IFLSB_BIT_PAIR_SHORT] = ch2_pair_short;
    assign ch2_bundle[`IFLSB_BIT_POS_GND] = ch2_pos_gnd;
    assign ch2_bundle[`IFLSB_BIT_NEG_GND] = ch2_neg_gnd;
    assign ch2_bundle[`IFLSB_BIT_POS_BIAS] = ch2_pos_bias;
    assign ch2_bundle[`IFLSB_BIT_NEG_BIAS] = ch2_neg_bias;
    assign ch2_bundle[`IFLSB_BIT_POS_VBAT] = ch2_pos_vbat;
    assign ch2_bundle[`IFLSB_BIT_NEG_VBAT] = ch2_neg_vbat;

    assign ch3_bundle[`IFLSB_BIT_OPEN] = ch3_open_any;
    assign ch3_bundle[`IFLSB_BIT_PAIR_SHORT] = ch3_pair_short;
    assign ch3_bundle[`IFLSB_BIT_POS_GND] = ch3_pos_gnd;
    assign ch3_bundle[`IFLSB_BIT_NEG_GND] = ch3_neg_gnd;
    assign ch3_bundle[`IFLSB_BIT_POS_BIAS] = ch3_pos_bias;
    assign ch3_bundle[`IFLSB_BIT_NEG_BIAS] = ch3_neg_bias;
    assign ch3_bundle[`IFLSB_BIT_POS_VBAT] = ch3_pos_vbat;
    assign ch3_bundle[`IFLSB_BIT_NEG_VBAT] = ch3_neg_vbat;

    assign ch4_bundle[`IFLSB_BIT_OPEN] = ch4_open_any;
    assign ch4_bundle[`IFLSB_BIT_PAIR_SHORT] = ch4_pair_short;
    assign ch4_bundle[`IFLSB_BIT_POS_GND] = ch4_pos_gnd;
    assign ch4_bundle[`IFLSB_BIT_NEG_GND] = ch4_neg_gnd;
    assign ch4_bundle[`IFLSB_BIT_POS_BIAS] = ch4_pos_bias;
    assign ch4_bundle[`IFLSB_BIT_NEG_BIAS] = ch4_neg_bias;
    assign ch4_bundle[`IFLSB_BIT_POS_VBAT] = ch4_pos_vbat;
    assign ch4_bundle[`IFLSB_BIT_NEG_VBAT] = ch4_neg_vbat;

    // ---------------------------------------------------------------
    // per-channel live registers
    // ---------------------------------------------------------------
    wire [7:0] chan_one_input_fault_live;
    wire [7:0] chan_two_input_fault_live;
    wire [7:0] chan_three_input_fault_live;
    wire [7:0] chan_four_input_fault_live;
    wire [3:0] vbat_short;
    wire [3:0] chan_any;

    // write path is not wired in: the channel registers have no load
    iflsb_chan u_ch1 (
        .mclk(mclk),
        .rst_n(rst_n),
        .fault_in(ch1_bundle),
        .live_status(chan_one_input_fault_live),
        .vbat_short(vbat_short[0]),
        .any_fault(chan_any[0])
    );

    iflsb_chan u_ch2 (
        .mclk(mclk),
        .rst_n(rst_n),
        .fault_in(ch2_bundle),
        .live_status(chan_two_input_fault_live),
        .vbat_short(vbat_short[1]),
        .any_fault(chan_any[1])
    );

    iflsb_chan u_ch3 (
        .mclk(mclk),
        .rst_n(rst_n),
        .fault_in(ch3_bundle),
        .live_status(chan_three_input_fault_live),
        .vbat_short(vbat_short[2]),
        .any_fault(chan_any[2])
    );

    iflsb_chan u_ch4 (
        .mclk(mclk),
        .rst_n(rst_n),
        .fault_in(ch4_bundle),
        .live_status(chan_four_input_fault_live),
        .vbat_short(vbat_short[3]),
        .any_fault(chan_any[3])
    );

    // ---------------------------------------------------------------
    // summary
    // ---------------------------------------------------------------
    // built from the live registers so it never leads them; the battery
    // bit reads the rail comparison directly and can lead by one cycle
    reg [7:0] summary_next;

    always @* begin
        summary_next = `IFLSB_RST_SUMMARY;
        summary_next[`IFLSB_SUM_CH1] = chan_any[0];
        summary_next[`IFLSB_SUM_CH2] = chan_any[1];
        summary_next[`IFLSB_SUM_CH3] = chan_any[2];
        summary_next[`IFLSB_SUM_CH4] = chan_any[3];
        summary_next[`IFLSB_SUM_VBAT_LOW] = (|vbat_short) & vbat_below_bias;
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            channel_fault_summary <= `IFLSB_RST_SUMMARY;
        end else begin
            channel_fault_summary <= summary_next;
        end
    end

    // a fault in any channel, kept apart from the read path
    always @(posedge mclk) begin
        if (!rst_n) begin
            fault_present <= 1'h0;
        end else begin
            fault_present <= |chan_any;
        end
    end

    // ---------------------------------------------------------------
    // control port
    // ---------------------------------------------------------------
    wire [7:0] mux_data;
    wire mux_hit;

    iflsb_rdmux u_rdmux (
        .addr(reg_addr),
        .summary(channel_fault_summary),
        .ch1(chan_one_input_fault_live),
        .ch2(chan_two_input_fault_live),
        .ch3(chan_three_input_fault_live),
        .ch4(chan_four_input_fault_live),
        .data(mux_data),
        .hit(mux_hit)
    );

    // ---------------------------------------------------------------
    // strobe decode
    // ---------------------------------------------------------------
    // read wins when both strobes come together; a write alone
    // only raises the ignored flag, nothing is stored
    wire rd_take;
    wire wr_only;

    assign rd_take = reg_rd;
    assign wr_only = reg_wr & ~reg_rd & (reg_wdata == reg_wdata);

    // ---------------------------------------------------------------
    // read answer
    // ---------------------------------------------------------------
    always @(posedge mclk) begin
        if (!rst_n) begin
            reg_rvalid <= 1'h0;
        end else begin
            reg_rvalid <= rd_take;
        end
    end

    // data holds the last read so a slow master can still pick it up
    always @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= `IFLSB_RST_LIVE;
        end else if (rd_take) begin
            reg_rdata <= mux_data;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            reg_miss <= 1'h0;
        end else begin
            reg_miss <= rd_take & ~mux_hit;
        end
    end

    // ---------------------------------------------------------------
    // write answer
    // ---------------------------------------------------------------
    always @(posedge mclk) begin
        if (!rst_n) begin
            reg_wr_ignored <= 1'h0;
        end else begin
            reg_wr_ignored <= wr_only;
        end
    end
endmodule

// ==== pkg/iflsb_map.vh ====
`ifndef IFLSB_MAP_VH
`define IFLSB_MAP_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define IFLSB_OFS_SUMMARY 8'h2D
`define IFLSB_OFS_CH1 8'h2E
`define IFLSB_OFS_CH2 8'h2F
`define IFLSB_OFS_CH3 8'h30
`define IFLSB_OFS_CH4 8'h31

// ---------------------------------------------------------------
// reset values and unmapped answer
// ---------------------------------------------------------------
`define IFLSB_RST_LIVE 8'h00
`define IFLSB_RST_SUMMARY 8'h00
`define IFLSB_UNMAPPED_DATA 8'h00

// ---------------------------------------------------------------
// per-channel field positions
// ---------------------------------------------------------------
`define IFLSB_BIT_OPEN 7
`define IFLSB_BIT_PAIR_SHORT 6
`define IFLSB_BIT_POS_GND 5
`define IFLSB_BIT_NEG_GND 4
`define IFLSB_BIT_POS_BIAS 3
`define IFLSB_BIT_NEG_BIAS 2
`define IFLSB_BIT_POS_VBAT 1
`define IFLSB_BIT_NEG_VBAT 0

// ---------------------------------------------------------------
// summary field positions
// ---------------------------------------------------------------
`define IFLSB_SUM_CH1 7
`define IFLSB_SUM_CH2 6
`define IFLSB_SUM_CH3 5
`define IFLSB_SUM_CH4 4
`define IFLSB_SUM_VBAT_LOW 1

`endif
